// ---- rtl/dsm_pkg.sv ----
// constants, types and arithmetic helpers of the digital sine modulator
// assumes one sample clock; every config and stream input comes from the same domain
package dsm_pkg;
	// -------------------------------------------------------------------
	// widths and counts
	// -------------------------------------------------------------------
	localparam int ACC_W = 32;
	localparam int PHASE_W = 16;
	localparam int SAMPLE_W = 16;
	localparam int GAIN_W = 16;
	localparam int HARM_W = 8;
	localparam int DEG_W = 9;
	localparam int OSC_NUM = 8;
	localparam int OSC_IDX_W = 3;
	localparam int NUM_LANES = 2;
	localparam int LANE_I = 0;
	localparam int LANE_Q = 1;
	localparam int GAIN_FRAC = 14;
	localparam int SAMPLE_FRAC = 15;
	localparam int BUF_DEPTH = 2;

	// -------------------------------------------------------------------
	// fixed values and reset values
	// -------------------------------------------------------------------
	localparam logic signed [GAIN_W-1:0] GAIN_ONE = 16'h4000;
	localparam logic signed [GAIN_W-1:0] GAIN_ZERO = 16'h0000;
	// i = cos, q = sin gives exp(+jwt): upper sideband for positive frequency
	localparam logic signed [GAIN_W-1:0] RST_I_SIN = GAIN_ZERO;
	localparam logic signed [GAIN_W-1:0] RST_I_COS = GAIN_ONE;
	localparam logic signed [GAIN_W-1:0] RST_Q_SIN = GAIN_ONE;
	localparam logic signed [GAIN_W-1:0] RST_Q_COS = GAIN_ZERO;
	localparam logic [HARM_W-1:0] RST_HARM = 8'h01;
	localparam logic [OSC_IDX_W-1:0] RST_OSC_SEL = 3'h0;
	localparam logic [ACC_W-1:0] RST_ACC = 32'h0000_0000;
	localparam logic [ACC_W-1:0] FREQ_RST = 32'h0000_0000;
	localparam logic [ACC_W-1:0] DEG_TO_PHASE = 32'h00b6_0b61; // 2^32 / 360, rounded
	localparam logic [DEG_W-1:0] DEG_QUARTER = 9'h05a;
	localparam logic [PHASE_W-1:0] PHASE_QUARTER = 16'h4000;
	localparam logic signed [33:0] SAT_MAX = 34'sh0_0000_7fff;
	localparam logic signed [33:0] SAT_MIN = 34'sh3_ffff_8000;

	typedef logic signed [SAMPLE_W-1:0] dsm_sample_type;

	// parabolic sine, one half wave per sign; good to about six percent of full scale
	function automatic dsm_sample_type dsm_sine(input logic [PHASE_W-1:0] p);
		logic [29:0] x;
		logic [29:0] prod;
		logic [15:0] mag;
		x = {15'h0000, p[14:0]};
		prod = x * (30'h0000_8000 - x);
		mag = (prod[29:13] > 17'h0_7fff) ? 16'h7fff : prod[28:13];
		return p[15] ? -$signed(mag) : $signed(mag);
	endfunction : dsm_sine

	// clip a wide signed value to the sample range
	function automatic dsm_sample_type dsm_sat(input logic signed [33:0] v);
		if (v > SAT_MAX) begin
			return 16'h7fff;
		end
		if (v < SAT_MIN) begin
			return 16'h8000;
		end
		return v[15:0];
	endfunction : dsm_sat
endpackage : dsm_pkg

// ---- rtl/dsm_stream_if.sv ----
// valid/ready sample stream between the modulator's own modules
// assumes both ends on core_clk; data is {i, q}
`timescale 1ns/10ps
interface dsm_stream_if #(
	parameter int DATA_W = 32
);
	logic valid;
	logic ready;
	logic [DATA_W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : dsm_stream_if

// ---- rtl/dsm_osc_bank.sv ----
// bank of oscillator frequency words with one write port and a registered read
// assumes writes and selection come from logic on core_clk
`timescale 1ns/10ps
module dsm_osc_bank #(
	parameter int OSC_COUNT = dsm_pkg::OSC_NUM
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// write port
	input wire logic wrEn,
	input wire logic [dsm_pkg::OSC_IDX_W-1:0] wrIdx,
	input wire logic [dsm_pkg::ACC_W-1:0] wrData,
	// read port
	input wire logic [dsm_pkg::OSC_IDX_W-1:0] rdIdx,
	output logic [dsm_pkg::ACC_W-1:0] rdData
);
	import dsm_pkg::*;

	if (OSC_COUNT != (1 << OSC_IDX_W)) begin : g_chk
		$error("oscillator count must fill the select field");
	end

	logic [ACC_W-1:0] freqReg [OSC_COUNT];

	// -------------------------------------------------------------------
	// one frequency word per oscillator
	// -------------------------------------------------------------------
	for (genvar k = 0; k < OSC_COUNT; k++) begin : g_osc
		always_ff @(posedge core_clk) begin
			if (!rst_b) begin
				freqReg[k] <= FREQ_RST;
			end else if (wrEn && (wrIdx == OSC_IDX_W'(k))) begin
				freqReg[k] <= wrData;
			end
		end
	end

	// read data from a register; a new word is seen two edges after its write
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rdData <= FREQ_RST;
		end else begin
			rdData <= freqReg[rdIdx];
		end
	end
endmodule : dsm_osc_bank

// ---- rtl/dsm_skid_buffer.sv ----
// two-entry buffer so that a stalling receiver loses no sample
// assumes both streams on core_clk
`timescale 1ns/10ps
module dsm_skid_buffer #(
	parameter int DATA_W = 32,
	parameter int DEPTH = dsm_pkg::BUF_DEPTH
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// streams
	dsm_stream_if.snk inS,
	dsm_stream_if.src outS
);
	import dsm_pkg::*;

	if (DEPTH != 2) begin : g_chk
		$error("buffer logic serves exactly two entries");
	end

	logic [DATA_W-1:0] slotReg [DEPTH];
	logic [1:0] countReg;
	logic push;
	logic pop;

	// honest full and empty from the count
	assign inS.ready = (countReg != 2'h2);
	assign outS.valid = (countReg != 2'h0);
	assign outS.data = slotReg[0];
	assign push = inS.valid && inS.ready;
	assign pop = outS.valid && outS.ready;

	// occupancy
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			countReg <= 2'h0;
		end else if (push && !pop) begin
			countReg <= countReg + 2'h1;
		end else if (pop && !push) begin
			countReg <= countReg - 2'h1;
		end
	end

	// slot 0 is the head; a pop shifts slot 1 forward
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			slotReg[0] <= '0;
			slotReg[1] <= '0;
		end else begin
			if (pop) begin
				slotReg[0] <= (countReg == 2'h2) ? slotReg[1] : inS.data;
			end else if (push && (countReg == 2'h0)) begin
				slotReg[0] <= inS.data;
			end
			if (push && ((countReg == 2'h2) || (countReg == 2'h1 && !pop))) begin
				slotReg[1] <= inS.data;
			end
		end
	end

	a_buf_no_overrun: assert property (@(posedge core_clk) disable iff (!rst_b)
		(countReg == 2'h2 && !pop) |=> (countReg == 2'h2))
		else $error("buffer count left full without a pop");
endmodule : dsm_skid_buffer

// ---- rtl/dsm_modulator.sv ----
// per-channel sine generation, i/q gain mixing and waveform modulation
// assumes config, oscillator writes and the waveform stream come from core_clk logic
`timescale 1ns/10ps

// Function
// - each channel holds eight oscillators, each with its own frequency word
// - a selector picks which oscillator drives the sine generator
// - sine runs at selected frequency times an integer harmonic factor
// - a phase offset given in degrees shifts the generated sinusoid
// - a gain scales the sine term feeding the in-phase mixer input
// - a separate gain scales the cosine term feeding the in-phase input
// - an on/off control suppresses the in-phase sinusoid when off
// - a gain scales the sine term feeding the quadrature mixer input
// - output is the waveform, or its product, sum, or both with the sinusoid per enables
// - reset gains give upper sideband for positive oscillator frequency
// - a separate gain scales the cosine term feeding the quadrature input
// - an on/off control suppresses the quadrature sinusoid when off
// - modulation enable selects multiplying waveform samples by the sinusoid
module dsm_modulator #(
	parameter int OSC_COUNT = dsm_pkg::OSC_NUM
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// oscillator frequency writes
	input wire logic oscWrEn,
	input wire logic [dsm_pkg::OSC_IDX_W-1:0] oscWrIdx,
	input wire logic [dsm_pkg::ACC_W-1:0] oscWrFreq,
	// configuration, taken on cfgLoad
	input wire logic cfgLoad,
	input wire logic [dsm_pkg::OSC_IDX_W-1:0] cfgOscSel,
	input wire logic [dsm_pkg::HARM_W-1:0] cfgHarmonic,
	input wire logic [dsm_pkg::DEG_W-1:0] cfgPhaseDeg,
	input wire logic signed [dsm_pkg::GAIN_W-1:0] cfgISinGain,
	input wire logic signed [dsm_pkg::GAIN_W-1:0] cfgICosGain,
	input wire logic signed [dsm_pkg::GAIN_W-1:0] cfgQSinGain,
	input wire logic signed [dsm_pkg::GAIN_W-1:0] cfgQCosGain,
	input wire logic cfgIEnable,
	input wire logic cfgQEnable,
	input wire logic cfgModEnable,
	input wire logic cfgAddEnable,
	// waveform samples in
	input wire logic awgValid,
	output logic awgReady,
	input wire logic signed [dsm_pkg::SAMPLE_W-1:0] awgI,
	input wire logic signed [dsm_pkg::SAMPLE_W-1:0] awgQ,
	// samples out to the dac path
	output logic outValid,
	input wire logic outReady,
	output logic signed [dsm_pkg::SAMPLE_W-1:0] outI,
	output logic signed [dsm_pkg::SAMPLE_W-1:0] outQ,
	// continuous mixer inputs, for plain sine output and status
	output logic signed [dsm_pkg::SAMPLE_W-1:0] mixIOut,
	output logic signed [dsm_pkg::SAMPLE_W-1:0] mixQOut
);
	import dsm_pkg::*;

	localparam int DATA_W = NUM_LANES * SAMPLE_W;

	if (OSC_COUNT != (1 << OSC_IDX_W)) begin : g_chk
		$error("oscillator count must fill the select field");
	end

	// -------------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------------
	logic signed [GAIN_W-1:0] gainSinReg [NUM_LANES];
	logic signed [GAIN_W-1:0] gainCosReg [NUM_LANES];
	logic [NUM_LANES-1:0] laneEnReg;
	logic [HARM_W-1:0] harmReg;
	logic [OSC_IDX_W-1:0] oscSelReg;
	logic [ACC_W-1:0] phaseOffReg;
	logic modEnReg;
	logic addEnReg;
	logic [ACC_W-1:0] freqRd;
	logic [ACC_W-1:0] stepWord;
	logic [ACC_W-1:0] accReg;
	logic [ACC_W-1:0] accNext;
	logic [PHASE_W-1:0] phase;
	dsm_sample_type sinV;
	dsm_sample_type cosV;
	dsm_sample_type mixReg [NUM_LANES];
	dsm_sample_type awgLane [NUM_LANES];
	dsm_sample_type outLane [NUM_LANES];
	logic accept;
	logic stgValidReg;
	logic [DATA_W-1:0] stgDataReg;

	dsm_stream_if #(.DATA_W(DATA_W)) stgIf ();
	dsm_stream_if #(.DATA_W(DATA_W)) outIf ();

	// -------------------------------------------------------------------
	// configuration registers
	// -------------------------------------------------------------------
	// one load strobe applies a whole set, so no half-updated i/q pair is seen
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			gainSinReg[LANE_I] <= RST_I_SIN;
			gainCosReg[LANE_I] <= RST_I_COS;
			gainSinReg[LANE_Q] <= RST_Q_SIN;
			gainCosReg[LANE_Q] <= RST_Q_COS;
			laneEnReg <= '1;
			harmReg <= RST_HARM;
			oscSelReg <= RST_OSC_SEL;
			phaseOffReg <= RST_ACC;
			modEnReg <= 1'b0;
			addEnReg <= 1'b0;
		end else if (cfgLoad) begin
			gainSinReg[LANE_I] <= cfgISinGain;
			gainCosReg[LANE_I] <= cfgICosGain;
			gainSinReg[LANE_Q] <= cfgQSinGain;
			gainCosReg[LANE_Q] <= cfgQCosGain;
			laneEnReg[LANE_I] <= cfgIEnable;
			laneEnReg[LANE_Q] <= cfgQEnable;
			harmReg <= cfgHarmonic;
			oscSelReg <= cfgOscSel;
			phaseOffReg <= ACC_W'(cfgPhaseDeg * DEG_TO_PHASE);
			modEnReg <= cfgModEnable;
			addEnReg <= cfgAddEnable;
		end
	end

	// -------------------------------------------------------------------
	// oscillator bank and phase accumulator
	// -------------------------------------------------------------------
	dsm_osc_bank #(.OSC_COUNT(OSC_COUNT)) u_bank (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.wrEn(oscWrEn),
		.wrIdx(oscWrIdx),
		.wrData(oscWrFreq),
		.rdIdx(oscSelReg),
		.rdData(freqRd)
	);

	// harmonic zero freezes the phase; that is the cheap way to hold a dc level
	assign stepWord = ACC_W'(freqRd * harmReg);
	assign accNext = accReg + stepWord;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			accReg <= RST_ACC;
		end else begin
			accReg <= accNext;
		end
	end

	// offset added after the accumulator, so a new phase takes effect at once
	assign phase = accReg[ACC_W-1 -: PHASE_W] + phaseOffReg[ACC_W-1 -: PHASE_W];
	assign sinV = dsm_sine(phase);
	assign cosV = dsm_sine(phase + PHASE_QUARTER);

	// -------------------------------------------------------------------
	// per-lane mixer input and modulation
	// -------------------------------------------------------------------
	assign awgLane[LANE_I] = awgI;
	assign awgLane[LANE_Q] = awgQ;

	for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
		logic signed [31:0] pSin;
		logic signed [31:0] pCos;
		logic signed [33:0] mixSum;
		logic signed [31:0] pMod;
		logic signed [33:0] modTerm;
		logic signed [33:0] addTerm;

		// gains are q2.14, so unity keeps the full sine amplitude
		assign pSin = sinV * gainSinReg[l];
		assign pCos = cosV * gainCosReg[l];
		assign mixSum = (34'(pSin) + 34'(pCos)) >>> GAIN_FRAC;

		always_ff @(posedge core_clk) begin
			if (!rst_b) begin
				mixReg[l] <= '0;
			end else if (laneEnReg[l]) begin
				mixReg[l] <= dsm_sat(mixSum);
			end else begin
				mixReg[l] <= '0;
			end
		end

		// product, sum or both; neither passes the waveform untouched
		assign pMod = awgLane[l] * mixReg[l];
		assign modTerm = modEnReg ? (34'(pMod) >>> SAMPLE_FRAC) : 34'(awgLane[l]);
		assign addTerm = addEnReg ? 34'(mixReg[l]) : '0;
		assign outLane[l] = dsm_sat(modTerm + addTerm);
	end

	assign mixIOut = mixReg[LANE_I];
	assign mixQOut = mixReg[LANE_Q];

	// -------------------------------------------------------------------
	// output stage and buffer
	// -------------------------------------------------------------------
	// the stage refills only when empty or when the buffer takes its word, so stalls reach the source
	assign awgReady = !stgValidReg || stgIf.ready;
	assign accept = awgValid && awgReady;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			stgValidReg <= 1'b0;
		end else if (accept) begin
			stgValidReg <= 1'b1;
		end else if (stgIf.ready) begin
			stgValidReg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			stgDataReg <= '0;
		end else if (accept) begin
			stgDataReg <= {outLane[LANE_I], outLane[LANE_Q]};
		end
	end

	assign stgIf.valid = stgValidReg;
	assign stgIf.data = stgDataReg;

	dsm_skid_buffer #(.DATA_W(DATA_W), .DEPTH(BUF_DEPTH)) u_buf (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.inS(stgIf),
		.outS(outIf)
	);

	assign outValid = outIf.valid;
	assign outIf.ready = outReady;
	assign outI = outIf.data[DATA_W-1 -: SAMPLE_W];
	assign outQ = outIf.data[SAMPLE_W-1:0];

	// -------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------
	sequence s_accept;
		awgValid && awgReady;
	endsequence

	sequence s_plain_accept;
		s_accept and (!modEnReg && !addEnReg);
	endsequence

	sequence s_write_then_hold;
		(oscWrEn && (oscWrIdx == oscSelReg) && !cfgLoad) ##1 (!oscWrEn && !cfgLoad);
	endsequence

	a_osc_pick_word: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_write_then_hold |=> (freqRd == $past(oscWrFreq, 2)))
		else $error("selected oscillator word not read back");

	a_acc_step_wrap: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(rst_b) |-> (accReg == ACC_W'($past(accReg) + ($past(freqRd) * $past(harmReg)))))
		else $error("accumulator step is not frequency times harmonic");

	a_phase_quarter: assert property (@(posedge core_clk) disable iff (!rst_b)
		(cfgLoad && cfgPhaseDeg == DEG_QUARTER) |=> (phaseOffReg[ACC_W-1 -: PHASE_W] == PHASE_QUARTER))
		else $error("ninety degrees does not give a quarter turn");

	a_reset_usb_gain: assert property (@(posedge core_clk) disable iff (!rst_b)
		!$past(rst_b) |-> (gainCosReg[LANE_I] == GAIN_ONE && gainSinReg[LANE_I] == GAIN_ZERO
			&& gainSinReg[LANE_Q] == GAIN_ONE && gainCosReg[LANE_Q] == GAIN_ZERO))
		else $error("reset gains do not give upper sideband");

	a_i_cos_unity: assert property (@(posedge core_clk) disable iff (!rst_b)
		(laneEnReg[LANE_I] && gainSinReg[LANE_I] == GAIN_ZERO && gainCosReg[LANE_I] == GAIN_ONE)
		|=> (mixReg[LANE_I] == $past(cosV)))
		else $error("in-phase mixer input is not the cosine");

	a_q_sin_unity: assert property (@(posedge core_clk) disable iff (!rst_b)
		(laneEnReg[LANE_Q] && gainSinReg[LANE_Q] == GAIN_ONE && gainCosReg[LANE_Q] == GAIN_ZERO)
		|=> (mixReg[LANE_Q] == $past(sinV)))
		else $error("quadrature mixer input is not the sine");

	a_i_lane_off: assert property (@(posedge core_clk) disable iff (!rst_b)
		(!laneEnReg[LANE_I] && !cfgLoad) |=> (mixReg[LANE_I] == '0)[*2])
		else $error("disabled in-phase input still carries a sinusoid");

	a_q_lane_off: assert property (@(posedge core_clk) disable iff (!rst_b)
		(!laneEnReg[LANE_Q] && !cfgLoad) |=> (mixReg[LANE_Q] == '0)[*2])
		else $error("disabled quadrature input still carries a sinusoid");

	a_pass_through: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_plain_accept |=> (stgValidReg && stgDataReg == $past({awgI, awgQ})))
		else $error("waveform not passed through with both modes off");

	a_mod_by_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		(s_accept and (modEnReg && !addEnReg && mixReg[LANE_I] == '0))
		|=> (stgDataReg[DATA_W-1 -: SAMPLE_W] == '0))
		else $error("product with a zero sinusoid is not zero");

	// adding a silent sinusoid must leave the waveform as it came in
	a_add_zero_mix: assert property (@(posedge core_clk) disable iff (!rst_b)
		(s_accept and (!modEnReg && addEnReg && mixReg[LANE_I] == '0))
		|=> (stgDataReg[DATA_W-1 -: SAMPLE_W] == $past(awgI)))
		else $error("sum with a zero sinusoid changed the waveform");

	// a stalled stage keeps its word, so a full buffer loses nothing
	a_stage_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		(stgValidReg && !stgIf.ready) |=> (stgValidReg && $stable(stgDataReg)))
		else $error("stalled output stage lost or changed its word");

	a_harm_zero_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		(harmReg == '0) |=> $stable(accReg))
		else $error("harmonic zero did not freeze the phase");
endmodule : dsm_modulator

// ---- tb/dsm_dac_sink.sv ----
// dac path model: takes output samples from the modulator with a chosen stall pattern
// assumes the modulator's output handshake runs on core_clk
`timescale 1ns/10ps
module dsm_dac_sink (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// sample stream from the modulator
	input wire logic outValid,
	input wire logic signed [dsm_pkg::SAMPLE_W-1:0] outI,
	input wire logic signed [dsm_pkg::SAMPLE_W-1:0] outQ,
	output logic outReady,
	// stall pattern: 0 always ready, 1 random, 2 held off
	input wire logic [1:0] stallMode
);
	import dsm_pkg::*;
	// ------------------------------------------------------------
	// capture
	// ------------------------------------------------------------
	logic [2*SAMPLE_W-1:0] gotQ[$];
	initial outReady = 1'b0;
	// a word counts only on an edge where both sides agree; ready changes after the edge
	always @(posedge core_clk) begin
		if (rst_b && outValid === 1'b1 && outReady === 1'b1) begin
			gotQ.push_back({outI, outQ});
		end
		case (stallMode)
			2'h0: outReady <= 1'b1;
			2'h1: outReady <= 1'($urandom);
			default: outReady <= 1'b0;
		endcase
	end
endmodule : dsm_dac_sink

// ---- tb/test_digital_sine_modulator.sv ----
// self-checking bench of the digital sine modulator with a dac path model
// assumes dsm_pkg, the design modules and dsm_dac_sink are compiled before it
`timescale 1ns/10ps
module test_digital_sine_modulator;
	import dsm_pkg::*;
	// ------------------------------------------------------------
	// signals, given reset-like values at time zero
	// ------------------------------------------------------------
	logic core_clk, awgReady, outValid, outReady;
	logic rst_b = 1'b0, oscWrEn = 1'b0, cfgLoad = 1'b0, awgValid = 1'b0;
	logic cfgIEnable = 1'b1, cfgQEnable = 1'b1, cfgModEnable = 1'b0, cfgAddEnable = 1'b0;
	logic [OSC_IDX_W-1:0] oscWrIdx = 3'h0, cfgOscSel = 3'h0;
	logic [ACC_W-1:0] oscWrFreq = 32'h0000_0000;
	logic [HARM_W-1:0] cfgHarmonic = 8'h01;
	logic [DEG_W-1:0] cfgPhaseDeg = 9'h000;
	dsm_sample_type cfgISinGain = 16'h0000, cfgICosGain = 16'h4000;
	dsm_sample_type cfgQSinGain = 16'h4000, cfgQCosGain = 16'h0000;
	dsm_sample_type awgI = 16'h0000, awgQ = 16'h0000, outI, outQ, mixIOut, mixQOut;
	logic [1:0] stallMode = 2'h0;
	logic [31:0] expQ[$];
	int err_count = 0, checked = 0;

	dsm_modulator #(.OSC_COUNT(OSC_NUM)) i_dsm_modulator (
		.core_clk(core_clk), .rst_b(rst_b), .oscWrEn(oscWrEn), .oscWrIdx(oscWrIdx),
		.oscWrFreq(oscWrFreq), .cfgLoad(cfgLoad), .cfgOscSel(cfgOscSel),
		.cfgHarmonic(cfgHarmonic), .cfgPhaseDeg(cfgPhaseDeg), .cfgISinGain(cfgISinGain),
		.cfgICosGain(cfgICosGain), .cfgQSinGain(cfgQSinGain), .cfgQCosGain(cfgQCosGain),
		.cfgIEnable(cfgIEnable), .cfgQEnable(cfgQEnable), .cfgModEnable(cfgModEnable),
		.cfgAddEnable(cfgAddEnable), .awgValid(awgValid), .awgReady(awgReady),
		.awgI(awgI), .awgQ(awgQ), .outValid(outValid), .outReady(outReady),
		.outI(outI), .outQ(outQ), .mixIOut(mixIOut), .mixQOut(mixQOut));

	dsm_dac_sink i_dsm_dac_sink (.core_clk(core_clk), .rst_b(rst_b), .outValid(outValid),
		.outI(outI), .outQ(outQ), .outReady(outReady), .stallMode(stallMode));

	// 100 ns period
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// ------------------------------------------------------------
	// reference arithmetic, same parabola as the hardware, not a true sine
	// ------------------------------------------------------------
	function automatic dsm_sample_type clip(input longint v);
		return (v > 32767) ? 16'h7fff : (v < -32768) ? 16'h8000 : 16'(v);
	endfunction : clip

	function automatic dsm_sample_type parab(input logic [15:0] p);
		longint x, m;
		x = p[14:0];
		m = (x * (32768 - x)) >>> 13;
		m = (m > 32767) ? 32767 : m;
		return p[15] ? 16'(-m) : 16'(m);
	endfunction : parab

	// static mixer value; only valid while the phase accumulator sits at zero
	function automatic dsm_sample_type mix_exp(input bit lane);
		logic [31:0] w;
		longint s, c, v;
		w = 32'(cfgPhaseDeg) * DEG_TO_PHASE;
		s = parab(w[31:16]);
		c = parab(w[31:16] + 16'h4000);
		v = lane ? s * cfgQSinGain + c * cfgQCosGain : s * cfgISinGain + c * cfgICosGain;
		return (lane ? cfgQEnable : cfgIEnable) ? clip(v >>> 14) : 16'h0000;
	endfunction : mix_exp

	function automatic dsm_sample_type out_exp(input dsm_sample_type a, input bit lane);
		longint m, v;
		m = mix_exp(lane);
		v = cfgModEnable ? (a * m) >>> 15 : a;
		return clip(cfgAddEnable ? v + m : v);
	endfunction : out_exp

	// ------------------------------------------------------------
	// compare and report
	// ------------------------------------------------------------
	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask : cmp_val

	task automatic cmp_count(input int got, input int exp);
		checked++;
		if (got != exp) begin
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask : cmp_count

	task automatic finish_test();
		$display("checked %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	// ------------------------------------------------------------
	// drivers, all changing inputs by non-blocking assignment at rising edges
	// ------------------------------------------------------------
	task automatic do_reset();
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(negedge core_clk);
		cmp_val(mixIOut, 16'h7fff);
		cmp_val(mixQOut, 16'h0000);
		@(posedge core_clk);
	endtask : do_reset

	task automatic osc_write(input logic [2:0] idx, input logic [31:0] f);
		@(posedge core_clk);
		oscWrEn <= 1'b1;
		oscWrIdx <= idx;
		oscWrFreq <= f;
		@(posedge core_clk);
		oscWrEn <= 1'b0;
	endtask : osc_write

	task automatic load(input logic [2:0] sel, input logic [7:0] harm);
		@(posedge core_clk);
		cfgOscSel <= sel;
		cfgHarmonic <= harm;
		cfgLoad <= 1'b1;
		@(posedge core_clk);
		cfgLoad <= 1'b0;
	endtask : load

	// quarter-turn steps: the next sine equals this cosine, and one peak shows in four
	task automatic chk_rot(input bit rot);
		dsm_sample_type pI, pQ;
		int peaks;
		peaks = 0;
		repeat (6) @(negedge core_clk);
		pI = mixIOut;
		pQ = mixQOut;
		repeat (4) begin
			@(negedge core_clk);
			cmp_val(mixQOut, rot ? pI : pQ);
			peaks += (mixQOut === 16'h7fff) ? 1 : 0;
			pI = mixIOut;
			pQ = mixQOut;
		end
		if (rot) begin
			cmp_count(peaks, 1);
		end
		@(posedge core_clk);
	endtask : chk_rot

	// holds the word until accepted; a refused word stays on the inputs
	task automatic send(input dsm_sample_type si, sq, input int bound, input bit must,
		output bit ok);
		int n;
		awgValid <= 1'b1;
		awgI <= si;
		awgQ <= sq;
		ok = 1'b0;
		for (n = 0; n < bound && !ok; n++) begin
			@(posedge core_clk);
			ok = (awgReady === 1'b1);
		end
		if (ok) begin
			expQ.push_back({out_exp(si, 1'b0), out_exp(sq, 1'b1)});
		end else if (must) begin
			err_count++;
			finish_test();
		end
	endtask : send

	task automatic drain();
		int n;
		logic [31:0] g;
		bit late;
		for (n = 0; n < 400 && i_dsm_dac_sink.gotQ.size() < expQ.size(); n++) begin
			@(posedge core_clk);
		end
		// a timeout only when words are still missing at the bound
		late = (i_dsm_dac_sink.gotQ.size() < expQ.size());
		cmp_count(i_dsm_dac_sink.gotQ.size(), expQ.size());
		while (expQ.size() > 0 && i_dsm_dac_sink.gotQ.size() > 0) begin
			g = i_dsm_dac_sink.gotQ.pop_front();
			cmp_val(g[31:16], expQ[0][31:16]);
			cmp_val(g[15:0], expQ[0][15:0]);
			void'(expQ.pop_front());
		end
		if (late) begin
			err_count++;
			finish_test();
		end
	endtask : drain

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		bit ok;
		int k;
		dsm_sample_type dI, dQ;
		void'($urandom(32'h899ba168));
		do_reset();
		// reset gains with a positive quarter-turn step rotate forwards
		osc_write(3'h0, 32'h4000_0000);
		chk_rot(1'b1);
		load(3'h0, 8'h02);
		osc_write(3'h0, 32'h2000_0000);
		chk_rot(1'b1);
		load(3'h0, 8'h00);
		chk_rot(1'b0);
		$display("test harmonic done, mismatches %0d", err_count);
		// only the selected word may move the phase
		for (k = 0; k < 8; k++) begin
			osc_write(3'(k + 7), 32'h0000_0000);
			osc_write(3'(k), 32'h4000_0000);
			load(3'(k), 8'h01);
			chk_rot(1'b1);
			load(3'(k + 1), 8'h01);
			chk_rot(1'b0);
		end
		$display("test select done, mismatches %0d", err_count);
		// second reset puts the accumulator back at zero for the static cases
		do_reset();
		stallMode <= 2'h1;
		for (k = 0; k < 40; k++) begin
			cfgPhaseDeg <= (k == 0) ? DEG_QUARTER : (k == 1) ? 9'h167 : 9'($urandom % 360);
			cfgISinGain <= (k < 2) ? GAIN_ONE : 16'($urandom);
			cfgICosGain <= (k == 2) ? 16'h7fff : 16'($urandom);
			cfgQSinGain <= (k == 2) ? 16'h8000 : 16'($urandom);
			cfgQCosGain <= (k < 2) ? GAIN_ZERO : 16'($urandom);
			{cfgIEnable, cfgQEnable} <= (k < 3) ? 2'h3 : 2'($urandom);
			cfgModEnable <= k[0];
			cfgAddEnable <= k[1];
			load(3'($urandom), 8'($urandom));
			repeat (3) @(negedge core_clk);
			cmp_val(mixIOut, mix_exp(1'b0));
			cmp_val(mixQOut, mix_exp(1'b1));
			@(posedge core_clk);
			send((k == 0) ? 16'h7fff : 16'($urandom), 16'($urandom), 200, 1'b1, ok);
			send((k == 0) ? 16'h8000 : 16'($urandom), 16'($urandom), 200, 1'b1, ok);
			send(16'($urandom), 16'($urandom), 200, 1'b1, ok);
			awgValid <= 1'b0;
			drain();
		end
		$display("test mixing done, mismatches %0d", err_count);
		// receiver held off: three words go in, the fourth is refused and kept
		stallMode <= 2'h2;
		repeat (3) @(posedge core_clk);
		k = 0;
		ok = 1'b1;
		while (ok && k < 6) begin
			dI = 16'($urandom);
			dQ = 16'($urandom);
			send(dI, dQ, 8, 1'b0, ok);
			k += ok ? 1 : 0;
		end
		cmp_count(k, 3);
		cmp_count(i_dsm_dac_sink.gotQ.size(), 0);
		stallMode <= 2'h1;
		send(dI, dQ, 200, 1'b1, ok);
		awgValid <= 1'b0;
		drain();
		$display("test buffer done, mismatches %0d", err_count);
		finish_test();
	end
endmodule : test_digital_sine_modulator
